// ===== logic/ldrc_top.sv
// Purpose: Control of ten linear regulators: voltage, modes, sequencing
// Assumes: Avalon-MM slave, one wait state, analog sits outside
// Notes:   Oscillator, thermal, power-good and request pins are async
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ldrc_regs.svh"
module ldrc_top #(
  parameter int NRAIL      = 10,
  parameter int VW         = 6,
  parameter int NPIN       = 7,
  parameter int RF_A       = 3,
  parameter int RF_B       = 4,
  parameter int SLOT_TICKS = `LDRC_SLOT_TICKS
) (
  // Clock and reset
  input  wire logic              CLOCK_IN,
  input  wire logic              NRST_IN,
  // Avalon-MM slave
  input  wire logic [6:0]        ADDRESS_IN,
  input  wire logic              READ_IN,
  input  wire logic              WRITE_IN,
  input  wire logic [3:0]        BYTEENABLE_IN,
  input  wire logic [31:0]       WRITEDATA_IN,
  output logic      [31:0]       READDATA_OUT,
  output logic                   WAITREQUEST_OUT,
  // Asynchronous device inputs
  input  wire logic              OSC32K_IN,
  input  wire logic              POWER_ON_IN,
  input  wire logic              DIE_HOT_WARNING_IN,
  input  wire logic              THERM_SHUTDOWN_IN,
  input  wire logic [NPIN-1:0]   REQUEST_PINS_IN,
  input  wire logic [NRAIL-1:0]  RAIL_OK_IN,
  // Regulator controls
  output logic [NRAIL-1:0]       RAIL_ENABLE_OUT,
  output logic [NRAIL-1:0]       LOW_QUIESCENT_OUT,
  output logic [NRAIL-1:0]       OUTPUT_PULLDOWN_OUT,
  output logic [NRAIL*VW-1:0]    VSEL_OUT,
  output logic [1:0]             THERM_LEVEL_OUT,
  // System
  output logic                   POWER_ON_RESET_N_OUT,
  output logic                   IRQ_OUT
);

  // Synchronised inputs
  logic              osc_s, pwr_s, hot_s, shut_s;
  logic [NPIN-1:0]   pin_s;
  logic [NRAIL-1:0]  ok_s;

  ldrc_sync #(
    .W(NRAIL + NPIN + 4)
  ) u_sync (
    .clk_in  (CLOCK_IN),
    .nrst_in (NRST_IN),
    .d_in    ({OSC32K_IN, POWER_ON_IN, DIE_HOT_WARNING_IN,
                THERM_SHUTDOWN_IN, REQUEST_PINS_IN, RAIL_OK_IN}),
    .q_out   ({osc_s, pwr_s, hot_s, shut_s, pin_s, ok_s})
  );

  // Word hit within a block of registers
  function automatic logic hit(input logic [6:0] a, input logic [6:0] base,
                               input int n);
    hit = (a[6:2] >= base[6:2]) && (int'(a[6:2]) < int'(base[6:2]) + n);
  endfunction : hit

  // Index within a block of registers
  function automatic int unsigned idx(input logic [6:0] a, input logic [6:0] base);
    idx = int'(a[6:2]) - int'(base[6:2]);
  endfunction : idx

  // Bus state
  logic        wreq_q, wreq_d;
  logic [31:0] rdata_q, rdata_d;
  logic        req, wr_now;
  logic [7:0]  wd;

  // Control registers
  logic [VW-1:0]    vsel_q [NRAIL];
  logic [VW-1:0]    vsel_d [NRAIL];
  logic [7:0]       cfg_q  [NRAIL];
  logic [7:0]       cfg_d  [NRAIL];
  logic [NRAIL-1:0] eco_q, eco_d, pd_q, pd_d, swen_q, swen_d;
  logic [1:0]       therm_q, therm_d, stat_q, stat_d, mask_q, mask_d;

  // Sequencer
  ldrc_pkg::ldrc_state_type st_q, st_d;
  logic [3:0]       slot_q, slot_d;
  logic [3:0]       tick_q, tick_d;
  logic             osc_prev_q;
  logic             tick_end;

  // Output registers
  logic [NRAIL-1:0]    en_q, en_d, lq_q, lq_d, pdo_q, pdo_d;
  logic [NRAIL*VW-1:0] vo_q, vo_d;
  logic                porn_q, porn_d, irq_q, irq_d;

  // Request decode; write commits on the edge waitrequest is low
  always_comb begin
    req    = READ_IN | WRITE_IN;
    wr_now = WRITE_IN & ~wreq_q & BYTEENABLE_IN[0];
    wd     = WRITEDATA_IN[7:0];
    wreq_d = ~(req & wreq_q);
  end

  // Read mux, captured during the wait cycle
  always_comb begin
    rdata_d = rdata_q;
    if (READ_IN && wreq_q) begin
      rdata_d = 32'h0;
      if (hit(ADDRESS_IN, `LDRC_VSEL_BASE, NRAIL)) begin
        rdata_d[VW-1:0] = vsel_q[idx(ADDRESS_IN, `LDRC_VSEL_BASE)];
      end else if (hit(ADDRESS_IN, `LDRC_CFG_BASE, NRAIL)) begin
        rdata_d[7:0] = cfg_q[idx(ADDRESS_IN, `LDRC_CFG_BASE)];
      end else begin
        case (ADDRESS_IN)
          `LDRC_ECO:       rdata_d[NRAIL-1:0] = eco_q;
          `LDRC_PULLDOWN:  rdata_d[NRAIL-1:0] = pd_q;
          `LDRC_SW_EN:     rdata_d[NRAIL-1:0] = swen_q;
          `LDRC_STATE:     rdata_d[5:0]       = {st_q, slot_q};
          `LDRC_THERM_CFG: rdata_d[1:0]       = therm_q;
          `LDRC_IRQ_STAT:  rdata_d[1:0]       = stat_q;
          `LDRC_IRQ_MASK:  rdata_d[1:0]       = mask_q;
          `LDRC_PG_A:      rdata_d[7:0]       = ok_s[7:0];
          `LDRC_PG_B:      rdata_d[NRAIL-9:0] = ok_s[NRAIL-1:8];
          default:         rdata_d            = 32'h0;
        endcase
      end
    end
  end

  // Software writes
  always_comb begin
    vsel_d  = vsel_q;
    cfg_d   = cfg_q;
    eco_d   = eco_q;
    pd_d    = pd_q;
    swen_d  = swen_q;
    therm_d = therm_q;
    mask_d  = mask_q;
    if (wr_now) begin
      if (hit(ADDRESS_IN, `LDRC_VSEL_BASE, NRAIL)) begin
        vsel_d[idx(ADDRESS_IN, `LDRC_VSEL_BASE)] = wd[VW-1:0];
      end else if (hit(ADDRESS_IN, `LDRC_CFG_BASE, NRAIL)) begin
        cfg_d[idx(ADDRESS_IN, `LDRC_CFG_BASE)] = wd;
      end else begin
        case (ADDRESS_IN)
          `LDRC_ECO:       eco_d   = WRITEDATA_IN[NRAIL-1:0];
          `LDRC_PULLDOWN:  pd_d    = WRITEDATA_IN[NRAIL-1:0];
          `LDRC_SW_EN:     swen_d  = WRITEDATA_IN[NRAIL-1:0];
          `LDRC_THERM_CFG: therm_d = wd[1:0];
          `LDRC_IRQ_MASK:  mask_d  = wd[1:0];
          default:         ;
        endcase
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins
  always_comb begin
    stat_d = stat_q;
    if (wr_now && ADDRESS_IN == `LDRC_IRQ_STAT) begin
      stat_d = stat_q & ~wd[1:0];
    end
    if (hot_s) begin
      stat_d[`LDRC_IRQ_HOT_BIT] = 1'b1;
    end
    if (shut_s) begin
      stat_d[`LDRC_IRQ_SHUT_BIT] = 1'b1;
    end
    irq_d = |(stat_d & ~mask_q);
  end

  // Slot timing from the 32 kHz oscillator
  always_comb begin
    tick_end = 1'b0;
    tick_d   = tick_q;
    if (st_q == ldrc_pkg::PWR_OFF || st_q == ldrc_pkg::PWR_ACTIVE) begin
      tick_d = 4'h0;
    end else if (osc_s && !osc_prev_q) begin
      if (int'(tick_q) >= SLOT_TICKS - 1) begin
        tick_end = 1'b1;
        tick_d   = 4'h0;
      end else begin
        tick_d = tick_q + 4'h1;
      end
    end
  end

  // Power sequencer
  always_comb begin
    st_d   = st_q;
    slot_d = slot_q;
    case (st_q)
      ldrc_pkg::PWR_OFF: begin
        slot_d = 4'h0;
        if (pwr_s) begin
          st_d = ldrc_pkg::PWR_UP;
        end
      end
      ldrc_pkg::PWR_UP: begin
        if (!pwr_s) begin
          st_d = ldrc_pkg::PWR_DOWN;
        end else if (tick_end) begin
          if (slot_q == `LDRC_LAST_SLOT) begin
            st_d = ldrc_pkg::PWR_ACTIVE;
          end else begin
            slot_d = slot_q + 4'h1;
          end
        end
      end
      ldrc_pkg::PWR_ACTIVE: begin
        slot_d = `LDRC_LAST_SLOT;
        if (!pwr_s) begin
          st_d = ldrc_pkg::PWR_DOWN;
        end
      end
      ldrc_pkg::PWR_DOWN: begin
        if (tick_end) begin
          if (slot_q == 4'h0) begin
            st_d = ldrc_pkg::PWR_OFF;
          end else begin
            slot_d = slot_q - 4'h1;
          end
        end
      end
      default: begin
        st_d   = ldrc_pkg::PWR_OFF;
        slot_d = 4'h0;
      end
    endcase
    if (shut_s) begin
      st_d   = ldrc_pkg::PWR_OFF;
      slot_d = 4'h0;
    end
  end

  // Per-rail enable, modes, pulldown and voltage outputs
  always_comb begin
    logic [3:0] s;
    logic [2:0] p;
    logic       live;
    s     = 4'h0;
    p     = 3'h0;
    live  = (st_q != ldrc_pkg::PWR_OFF) && !shut_s && (st_d != ldrc_pkg::PWR_OFF);
    en_d  = '0;
    lq_d  = '0;
    pdo_d = '0;
    vo_d  = '0;
    for (int i = 0; i < NRAIL; i++) begin
      s = cfg_q[i][`LDRC_CFG_SLOT_LSB +: 4];
      p = cfg_q[i][`LDRC_CFG_SEL_LSB +: 3];
      if (live) begin
        if (cfg_q[i][`LDRC_CFG_PIN_BIT]) begin
          en_d[i] = (int'(p) < NPIN) ? pin_s[p] : 1'b0;
        end else begin
          en_d[i] = swen_q[i] | ((s != 4'h0) && (s <= slot_q));
        end
      end
      lq_d[i]  = eco_q[i] & en_d[i];
      pdo_d[i] = pd_q[i] & ~en_d[i];
      vo_d[i*VW +: VW] = vsel_q[i];
      if (i == RF_A || i == RF_B) begin
        vo_d[i*VW + VW - 1] = 1'b1;
      end
    end
    porn_d = live;
  end

  // Bus registers
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wreq_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wreq_q  <= wreq_d;
      rdata_q <= rdata_d;
    end
  end

  // Control registers
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      for (int i = 0; i < NRAIL; i++) begin
        vsel_q[i] <= `LDRC_VSEL_RST;
        cfg_q[i]  <= `LDRC_CFG_RST;
      end
      eco_q   <= '0;
      pd_q    <= '0;
      swen_q  <= '0;
      therm_q <= `LDRC_THERM_RST;
      mask_q  <= `LDRC_MASK_RST;
      stat_q  <= 2'h0;
    end else begin
      vsel_q  <= vsel_d;
      cfg_q   <= cfg_d;
      eco_q   <= eco_d;
      pd_q    <= pd_d;
      swen_q  <= swen_d;
      therm_q <= therm_d;
      mask_q  <= mask_d;
      stat_q  <= stat_d;
    end
  end

  // Sequencer registers
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st_q       <= ldrc_pkg::PWR_OFF;
      slot_q     <= 4'h0;
      tick_q     <= 4'h0;
      osc_prev_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      slot_q     <= slot_d;
      tick_q     <= tick_d;
      osc_prev_q <= osc_s;
    end
  end

  // Output registers
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      en_q   <= '0;
      lq_q   <= '0;
      pdo_q  <= '0;
      vo_q   <= '0;
      porn_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      en_q   <= en_d;
      lq_q   <= lq_d;
      pdo_q  <= pdo_d;
      vo_q   <= vo_d;
      porn_q <= porn_d;
      irq_q  <= irq_d;
    end
  end

  // Ports from flip-flops
  assign READDATA_OUT         = rdata_q;
  assign WAITREQUEST_OUT      = wreq_q;
  assign RAIL_ENABLE_OUT      = en_q;
  assign LOW_QUIESCENT_OUT    = lq_q;
  assign OUTPUT_PULLDOWN_OUT  = pdo_q;
  assign VSEL_OUT             = vo_q;
  assign THERM_LEVEL_OUT      = therm_q;
  assign POWER_ON_RESET_N_OUT = porn_q;
  assign IRQ_OUT              = irq_q;

endmodule : ldrc_top

// ===== inc/ldrc_regs.svh
// Purpose: Register map, fields, resets and timing of the rail control
// Assumes: 32-bit Avalon-MM words, byte addresses, 8-bit or 10-bit data in low bits
// Notes:   Rail index 0..9; the two low-noise rails sit at RF_A/RF_B
// Contract
// - Per-rail voltage setting, applied at once
// - Per-rail low-quiescent mode enable bit
// - Pulldown bit grounds output, ignored while enabled
// - Die-hot warning interrupts unless masked
// - Warning level selectable; shutdown forces off state
// - Rail uses time slot or enable pin
// - Seven request pins map to any rail
// - Low-noise rails force voltage bit five high
// - Power-good comparators shown in two status registers
// - Sequencing timed from internal 32 kHz oscillator
// - Off state: supplies off, reset held
`ifndef LDRC_REGS_SVH
`define LDRC_REGS_SVH

// Register byte offsets
`define LDRC_VSEL_BASE  7'h00
`define LDRC_ECO        7'h28
`define LDRC_PULLDOWN   7'h2c
`define LDRC_SW_EN      7'h30
`define LDRC_STATE      7'h34
`define LDRC_THERM_CFG  7'h38
`define LDRC_IRQ_STAT   7'h3c
`define LDRC_CFG_BASE   7'h40
`define LDRC_IRQ_MASK   7'h68
`define LDRC_PG_A       7'h6c
`define LDRC_PG_B       7'h70

// Rail configuration fields
`define LDRC_CFG_SLOT_LSB  0
`define LDRC_CFG_SEL_LSB   4
`define LDRC_CFG_PIN_BIT   7

// Interrupt status bits
`define LDRC_IRQ_HOT_BIT   0
`define LDRC_IRQ_SHUT_BIT  1

// Reset values
`define LDRC_VSEL_RST   6'h00
`define LDRC_CFG_RST    8'h00
`define LDRC_THERM_RST  2'h0
`define LDRC_MASK_RST   2'h3

// Timing
`define LDRC_LAST_SLOT   4'hf
`define LDRC_SLOT_TICKS  4

`endif

// ===== inc/ldrc_pkg.sv
// Purpose: Shared types of the rail control
// Assumes: Constants live in ldrc_regs.svh
// Notes:   Power state codes read back in the state register
package ldrc_pkg;

  // Power sequencer state
  typedef enum logic [1:0] {
    PWR_OFF    = 2'b00,
    PWR_UP     = 2'b01,
    PWR_ACTIVE = 2'b10,
    PWR_DOWN   = 2'b11
  } ldrc_state_type;

endpackage : ldrc_pkg

// ===== logic/ldrc_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk_in
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
module ldrc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] s1_q, s2_q, s3_q, o_q;
  logic [W-1:0] o_d;

  // Take new value per bit only on agreement
  always_comb begin
    for (int i = 0; i < W; i++) begin
      o_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : o_q[i];
    end
  end

  // Stages
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      o_q  <= '0;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      o_q  <= o_d;
    end
  end

  assign q_out = o_q;

endmodule : ldrc_sync

// ===== verif/ldrc_props.sv
// Purpose: Assertions on bus timing, rail outputs and interrupt
// Assumes: One clock domain, bound to the top
// Notes:   Sees top ports only
`timescale 1ns/1ps
module ldrc_props #(
  parameter int NRAIL = 10,
  parameter int VW    = 6,
  parameter int RF_A  = 3,
  parameter int RF_B  = 4
) (
  // Clock, reset and bus
  input wire logic                CLOCK_IN,
  input wire logic                NRST_IN,
  input wire logic                READ_IN,
  input wire logic                WRITE_IN,
  input wire logic                WAITREQUEST_OUT,
  // Device side
  input wire logic                THERM_SHUTDOWN_IN,
  input wire logic [NRAIL-1:0]    RAIL_ENABLE_OUT,
  input wire logic [NRAIL-1:0]    LOW_QUIESCENT_OUT,
  input wire logic [NRAIL-1:0]    OUTPUT_PULLDOWN_OUT,
  input wire logic [NRAIL*VW-1:0] VSEL_OUT,
  input wire logic                POWER_ON_RESET_N_OUT,
  input wire logic                IRQ_OUT
);
  default clocking @(posedge CLOCK_IN);
  endclocking
  default disable iff (!NRST_IN);
  // Exactly one wait state, then back high
  AST_ONE_WAIT: assert property ((READ_IN || WRITE_IN) && WAITREQUEST_OUT
    |=> !WAITREQUEST_OUT ##1 WAITREQUEST_OUT) else $error("Wait state count wrong");
  AST_IDLE_WAIT: assert property (!READ_IN && !WRITE_IN |=> WAITREQUEST_OUT)
    else $error("Answer without request");
  // Mode outputs gated by rail enable
  AST_ECO_GATE: assert property ((LOW_QUIESCENT_OUT & ~RAIL_ENABLE_OUT) == '0)
    else $error("Quiet mode on idle rail");
  AST_PD_GATE: assert property ((OUTPUT_PULLDOWN_OUT & RAIL_ENABLE_OUT) == '0)
    else $error("Pulldown on live rail");
  // Low-noise rail keeps top select bit
  AST_RF_TOP: assert property (RAIL_ENABLE_OUT[RF_A] || RAIL_ENABLE_OUT[RF_B] |->
    VSEL_OUT[RF_A*VW+VW-1] && VSEL_OUT[RF_B*VW+VW-1]) else $error("Top select bit low");
  // Shutdown drops rails and holds reset
  AST_SHUT_EN: assert property (THERM_SHUTDOWN_IN [*8] |-> RAIL_ENABLE_OUT == '0)
    else $error("Rails on in shutdown");
  AST_SHUT_POR: assert property (THERM_SHUTDOWN_IN [*8] |=> !POWER_ON_RESET_N_OUT)
    else $error("Reset released in shutdown");
  // Interrupt falls only after a host write
  AST_IRQ_HOLD: assert property ($fell(IRQ_OUT) |->
    $past(WRITE_IN) || $past(WRITE_IN, 2) || $past(WRITE_IN, 3)) else $error("Irq lost");
endmodule : ldrc_props

bind ldrc_top ldrc_props #(.NRAIL(NRAIL), .VW(VW), .RF_A(RF_A), .RF_B(RF_B)) u_props (
  .CLOCK_IN(CLOCK_IN),
  .NRST_IN(NRST_IN),
  .READ_IN(READ_IN),
  .WRITE_IN(WRITE_IN),
  .WAITREQUEST_OUT(WAITREQUEST_OUT),
  .THERM_SHUTDOWN_IN(THERM_SHUTDOWN_IN),
  .RAIL_ENABLE_OUT(RAIL_ENABLE_OUT),
  .LOW_QUIESCENT_OUT(LOW_QUIESCENT_OUT),
  .OUTPUT_PULLDOWN_OUT(OUTPUT_PULLDOWN_OUT),
  .VSEL_OUT(VSEL_OUT),
  .POWER_ON_RESET_N_OUT(POWER_ON_RESET_N_OUT),
  .IRQ_OUT(IRQ_OUT)
);

// ===== verif/ldrc_host.sv
// Purpose: Host model issuing register bus accesses
// Assumes: One access at a time, started by a go pulse
// Notes:   Idle address and data show inverted last value
`timescale 1ns/1ps
module ldrc_host (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Command side
  input  wire logic        go_in,
  input  wire logic        we_in,
  input  wire logic [6:0]  addr_in,
  input  wire logic [31:0] data_in,
  output logic             done_out,
  output logic [31:0]      rdata_out,
  // Bus side
  input  wire logic        wait_in,
  input  wire logic [31:0] bus_rdata_in,
  output logic             rd_out,
  output logic             wr_out,
  output logic [6:0]       addr_out,
  output logic [31:0]      wdata_out
);
  // Request held until waitrequest seen low
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {rd_out, wr_out, done_out} <= 3'h0;
      addr_out <= 7'h7f;
      wdata_out <= 32'h0;
      rdata_out <= 32'h0;
    end else if ((rd_out || wr_out) && !wait_in) begin
      {rd_out, wr_out, done_out} <= 3'h1;
      rdata_out <= bus_rdata_in;
      addr_out <= ~addr_out;
      wdata_out <= ~wdata_out;
    end else if (go_in && !rd_out && !wr_out) begin
      {rd_out, wr_out, done_out} <= {!we_in, we_in, 1'b0};
      addr_out <= addr_in;
      wdata_out <= data_in;
    end else begin
      done_out <= 1'b0;
    end
  end
endmodule : ldrc_host

// ===== verif/tb_top.sv
// Purpose: Self-checking bench of the rail control
// Assumes: Host model makes every register access
// Notes:   Oscillator sped up so slots pass quickly
`timescale 1ns/1ps
`include "ldrc_regs.svh"
module tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        go = 1'b0;
  logic        we = 1'b0;
  logic [6:0]  ha = 7'h00;
  logic [31:0] hd = 32'h0;
  logic        pwr = 1'b0;
  logic        hot = 1'b0;
  logic        shut = 1'b0;
  logic [6:0]  pins = 7'h00;
  logic [9:0]  ok = 10'h000;
  logic [3:0]  osc = 4'h0;
  logic        done, rd, wr, wq, porn, irq;
  logic [6:0]  ba;
  logic [31:0] hr, bw, br;
  logic [9:0]  en, lq, pd;
  logic [59:0] vs;
  logic [1:0]  tl;
  int          n_errors = 0;
  int          compares = 0;

  always #5 clk = ~clk;
  // Oscillator stand-in, 16 clocks a period
  always @(posedge clk) osc <= osc + 4'h1;

  ldrc_host u_host (.clk_in(clk), .nrst_in(nrst), .go_in(go), .we_in(we), .addr_in(ha),
    .data_in(hd), .done_out(done), .rdata_out(hr), .wait_in(wq), .bus_rdata_in(br),
    .rd_out(rd), .wr_out(wr), .addr_out(ba), .wdata_out(bw));
  ldrc_top #(.SLOT_TICKS(1)) u_dut (.CLOCK_IN(clk), .NRST_IN(nrst), .ADDRESS_IN(ba),
    .READ_IN(rd), .WRITE_IN(wr), .BYTEENABLE_IN(4'h1), .WRITEDATA_IN(bw),
    .READDATA_OUT(br), .WAITREQUEST_OUT(wq), .OSC32K_IN(osc[3]), .POWER_ON_IN(pwr),
    .DIE_HOT_WARNING_IN(hot), .THERM_SHUTDOWN_IN(shut), .REQUEST_PINS_IN(pins),
    .RAIL_OK_IN(ok), .RAIL_ENABLE_OUT(en), .LOW_QUIESCENT_OUT(lq),
    .OUTPUT_PULLDOWN_OUT(pd), .VSEL_OUT(vs), .THERM_LEVEL_OUT(tl),
    .POWER_ON_RESET_N_OUT(porn), .IRQ_OUT(irq));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One host access, bounded wait
  task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    we <= w;
    ha <= a;
    hd <= d;
    @(posedge clk);
    go <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 40) chk("bus_done", 32'h1, 32'h0);
  endtask : acc

  task automatic rdchk(input string nm, input logic [6:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(nm, e, hr);
  endtask : rdchk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  // Poll the state register until the wanted state, bounded
  task automatic wait_state(input logic [1:0] s);
    int n;
    n = 0;
    acc(1'b0, `LDRC_STATE, 32'h0);
    while (hr[5:4] !== s && n < 60) begin
      wt(8);
      acc(1'b0, `LDRC_STATE, 32'h0);
      n++;
    end
  endtask : wait_state

  // Low-noise rails show top bit set on the voltage outputs
  function automatic logic [5:0] vexp(input int i, input logic [5:0] v);
    return (i == 3 || i == 4) ? (v | 6'h20) : v;
  endfunction : vexp

  task automatic final_report;
    $display("Compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report;
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    logic [9:0]  e;
    logic [5:0]  v [10];
    void'($urandom(32'h3c99691c));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rdchk("mask_rst", `LDRC_IRQ_MASK, 32'h3);
    acc(1'b1, 7'h7c, 32'hff);
    rdchk("unmapped", 7'h7c, 32'h0);
    for (int i = 0; i < 10; i++) begin
      v[i] = 6'($urandom);
      acc(1'b1, 7'(4 * i), {26'h0, v[i]});
    end
    for (int i = 0; i < 10; i++) begin
      rdchk("vsel_rd", 7'(4 * i), {26'h0, v[i]});
      chk("vsel_out", {26'h0, vexp(i, v[i])}, {26'h0, vs[i*6 +: 6]});
    end
    for (int t = 0; t < 4; t++) begin
      acc(1'b1, `LDRC_THERM_CFG, 32'(t));
      wt(1);
      chk("therm_lvl", 32'(t), {30'h0, tl});
    end
    // Slots incl. last one and an unsequenced rail
    for (int i = 0; i < 9; i++) begin
      acc(1'b1, 7'(`LDRC_CFG_BASE + 4 * i), (i == 7) ? 32'hf : (i == 8) ? 32'h0 : 32'(i + 1));
    end
    @(posedge clk);
    pwr <= 1'b1;
    wait_state(2'h2);
    wt(2);
    chk("state", 32'h2f, hr);
    chk("rails_up", 32'h0ff, {22'h0, en});
    chk("por_n", 32'h1, {31'h0, porn});
    // Every request pin drives the last rail; index seven is off
    for (int p = 0; p < 8; p++) begin
      acc(1'b1, 7'(`LDRC_CFG_BASE + 36), 32'h80 | 32'(p << 4));
      for (int l = 1; l >= 0; l--) begin
        @(posedge clk);
        pins <= (p == 7) ? {7{l[0]}} : 7'(l << p);
        wt(8);
        chk("pin_rail", 32'(l != 0 && p != 7), {31'h0, en[9]});
      end
    end
    r = $urandom;
    e = {1'b0, r[8], 8'hff};
    acc(1'b1, `LDRC_SW_EN, {22'h0, r[9:0]});
    acc(1'b1, `LDRC_ECO, {22'h0, r[19:10]});
    acc(1'b1, `LDRC_PULLDOWN, {22'h0, r[29:20]});
    wt(2);
    chk("rail_en", {22'h0, e}, {22'h0, en});
    chk("low_q", {22'h0, r[19:10] & e}, {22'h0, lq});
    chk("pulldown", {22'h0, r[29:20] & ~e}, {22'h0, pd});
    // Power-down walks the slots back to off, then up again
    @(posedge clk);
    pwr <= 1'b0;
    wt(20);
    acc(1'b0, `LDRC_STATE, 32'h0);
    chk("down_mid", 32'h3, {30'h0, hr[5:4]});
    wait_state(2'h0);
    wt(2);
    chk("down_state", 32'h0, hr);
    chk("down_rails", 32'h0, {22'h0, en});
    chk("down_por", 32'h0, {31'h0, porn});
    chk("down_pd", {22'h0, r[29:20]}, {22'h0, pd});
    chk("down_lq", 32'h0, {22'h0, lq});
    @(posedge clk);
    pwr <= 1'b1;
    wait_state(2'h2);
    wt(2);
    chk("re_up", {22'h0, e}, {22'h0, en});
    // Voltage change on a live rail shows at once
    acc(1'b1, 7'h00, {26'h0, ~v[0]});
    wt(1);
    chk("vsel_live", {26'h0, ~v[0]}, {26'h0, vs[5:0]});
    // Supplies above one volt, so bits are valid
    @(posedge clk);
    ok <= 10'($urandom);
    wt(8);
    rdchk("pg_a", `LDRC_PG_A, {24'h0, ok[7:0]});
    rdchk("pg_b", `LDRC_PG_B, {30'h0, ok[9:8]});
    // Short warning pulse, latched, masked, cleared
    acc(1'b1, `LDRC_IRQ_MASK, 32'h2);
    @(posedge clk);
    hot <= 1'b1;
    wt(10);
    @(posedge clk);
    hot <= 1'b0;
    wt(10);
    chk("irq_latched", 32'h1, {31'h0, irq});
    rdchk("irq_stat", `LDRC_IRQ_STAT, 32'h1);
    acc(1'b1, `LDRC_IRQ_MASK, 32'h3);
    wt(3);
    chk("irq_masked", 32'h0, {31'h0, irq});
    acc(1'b1, `LDRC_IRQ_MASK, 32'h2);
    acc(1'b1, `LDRC_IRQ_STAT, 32'h1);
    wt(3);
    chk("irq_clear", 32'h0, {31'h0, irq});
    @(posedge clk);
    shut <= 1'b1;
    wt(10);
    chk("shut_en", 32'h0, {22'h0, en});
    chk("shut_por", 32'h0, {31'h0, porn});
    acc(1'b0, `LDRC_STATE, 32'h0);
    chk("shut_state", 32'h0, {30'h0, hr[5:4]});
    rdchk("shut_irq", `LDRC_IRQ_STAT, 32'h2);
    // Reset in mid-run brings registers back
    @(posedge clk);
    nrst <= 1'b0;
    shut <= 1'b0;
    wt(3);
    chk("rst_wait", 32'h1, {31'h0, wq});
    chk("rst_por", 32'h0, {31'h0, porn});
    @(posedge clk);
    nrst <= 1'b1;
    rdchk("mask_rst2", `LDRC_IRQ_MASK, 32'h3);
    rdchk("stat_rst", `LDRC_IRQ_STAT, 32'h0);
    rdchk("vsel_rst", 7'h00, 32'h0);
    final_report;
  end
endmodule : tb_top
